// ### gpe_consts.vh
// gpe_consts.vh: register indices, field positions, reset values and
// timing counts for the gpio port with event detection.
// assumes inclusion by the port module only.
`ifndef GPE_CONSTS_VH
`define GPE_CONSTS_VH

// configuration space indices
`define GPE_IDX_SEL 8'hF0
`define GPE_IDX_CFG1 8'hF1
`define GPE_IDX_ROUTE 8'hF2
`define GPE_IDX_CFG2 8'hF3
`define GPE_IDX_MODE 8'hF8

// runtime register offsets
`define GPE_OFS_DOUT 3'h0
`define GPE_OFS_DIN 3'h1
`define GPE_OFS_EVEN 3'h2
`define GPE_OFS_EVST 3'h3
`define GPE_OFS_DIO 3'h4

// pin_config_one fields
`define GPE_C1_OE 0
`define GPE_C1_OD 1
`define GPE_C1_PU 2
`define GPE_C1_LOCK 3
`define GPE_C1_ETYPE 4
`define GPE_C1_EPOL 5
`define GPE_C1_DBNC 6
// pin_config_two field
`define GPE_C2_VDDL 4
// event_routing field
`define GPE_RT_IRQ 0
// mode field
`define GPE_MD_SEP 0

// reset values
`define GPE_RST_CFG1 8'h40
`define GPE_RST_ROUTE 8'h01
`define GPE_RST_CFG2 8'h00
`define GPE_RST_MODE 8'h01
`define GPE_RST_DOUT 8'hFF

// debounce timing
`define GPE_DBNC_MS 16
`define GPE_CLK_KHZ 50000
`define GPE_DBNC_CYC (`GPE_DBNC_MS * `GPE_CLK_KHZ)

`endif

// ### gpe_pins_model.sv
// gpe_pins_model.sv: outside circuitry on the eight port pins.
// assumes the port's driver and enable outputs.
`timescale 1ns/1ps
module gpe_pins_model (
	// from the port
	input wire [7:0] drv_in,
	input wire [7:0] oe_in,
	// from the bench
	input wire [7:0] ext_in,
	// resolved pin levels
	output wire [7:0] level_out
);
	// outside drivers yield wherever the port drives
	assign level_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule

// ### gpe_port.v
// gpe_port.v: one 8-pin gpio port with per-pin configuration, lock,
// load protection, debounced event detection and an interrupt request.
// assumes a decoded config port and runtime port, both synchronous.
`timescale 1ns/1ps
`include "gpe_consts.vh"

module gpe_port #(
	parameter PINS = 8,
	parameter DBNC_CYC = `GPE_DBNC_CYC
)(
	// clock and reset
	input wire REF_CLK_IN,
	input wire SYS_RST_IN,
	// power and activation
	input wire MAIN_PWR_OK_IN,
	input wire MOD_ACTIVE_IN,
	// configuration port
	input wire CFG_WR_IN,
	input wire CFG_RD_IN,
	input wire [7:0] CFG_IDX_IN,
	input wire [7:0] CFG_WDATA_IN,
	output reg [7:0] CFG_RDATA_OUT,
	// runtime port
	input wire RT_WR_IN,
	input wire RT_RD_IN,
	input wire [2:0] RT_OFS_IN,
	input wire [7:0] RT_WDATA_IN,
	output reg [7:0] RT_RDATA_OUT,
	// pins
	input wire [PINS-1:0] PIN_IN,
	output reg [PINS-1:0] PIN_OUT,
	output reg [PINS-1:0] PIN_OE_OUT,
	output reg [PINS-1:0] PIN_PU_OUT,
	// interrupt request to the serializer
	output reg IRQ_OUT
);

	localparam CW = 24;

	reg [7:0] sel_q;
	reg [7:0] mode_q;
	reg [7:0] cfg1_q [0:PINS-1];
	reg [7:0] cfg2_q [0:PINS-1];
	reg [7:0] route_q [0:PINS-1];
	reg [PINS-1:0] dout_q;
	reg [PINS-1:0] even_q;
	reg [PINS-1:0] evst_q;
	reg [PINS-1:0] sync1_q;
	reg [PINS-1:0] sync2_q;
	reg [PINS-1:0] stab_q;
	reg [PINS-1:0] det_q;
	reg [PINS-1:0] det_prev_q;
	reg [PINS-1:0] pend_q;
	reg [CW-1:0] dcnt_q [0:PINS-1];
	reg pwr_prev_q;
	reg [PINS-1:0] vddl_v;
	reg [PINS-1:0] route_v;
	reg [PINS-1:0] evst_clr_v;
	reg [PINS-1:0] evst_drop_v;
	reg [PINS-1:0] evst_d;

	wire [2:0] sel = sel_q[2:0];
	wire sep_mode = mode_q[`GPE_MD_SEP];
	wire rt_open = MOD_ACTIVE_IN;
	wire ev_open = MOD_ACTIVE_IN && MAIN_PWR_OK_IN;
	wire pwr_fall = pwr_prev_q && !MAIN_PWR_OK_IN;
	wire cfg_wr = CFG_WR_IN;

	// runtime write strobes, gated by activation and, except the dio strobe, by mode
	wire wr_dout = RT_WR_IN && rt_open && sep_mode &&
		RT_OFS_IN == `GPE_OFS_DOUT;
	wire wr_dio = RT_WR_IN && rt_open && RT_OFS_IN == `GPE_OFS_DIO;
	wire wr_even = RT_WR_IN && ev_open && sep_mode &&
		RT_OFS_IN == `GPE_OFS_EVEN;
	wire wr_evst = RT_WR_IN && ev_open && sep_mode &&
		RT_OFS_IN == `GPE_OFS_EVST;

	reg [PINS-1:0] lock_v;
	reg [PINS-1:0] prot_v;
	reg [PINS-1:0] hit_v;
	integer k;
	always @*
	begin
		lock_v = {PINS{1'b0}};
		prot_v = {PINS{1'b0}};
		hit_v = {PINS{1'b0}};
		for (k = 0; k < PINS; k = k + 1)
		begin
			lock_v[k] = cfg1_q[k][`GPE_C1_LOCK];
			prot_v[k] = cfg2_q[k][`GPE_C2_VDDL] && !MAIN_PWR_OK_IN;
			if (cfg1_q[k][`GPE_C1_ETYPE])
				hit_v[k] = (det_q[k] == cfg1_q[k][`GPE_C1_EPOL]);
			else
				hit_v[k] = (det_q[k] != det_prev_q[k]) &&
					(det_q[k] == cfg1_q[k][`GPE_C1_EPOL]);
		end
	end

	genvar g;
	generate
		for (g = 0; g < PINS; g = g + 1)
		begin : pin_g
			wire in_live = sync2_q[g] && !prot_v[g];
			// pin configuration registers, selected by the pin index
			always @(posedge REF_CLK_IN)
			begin
				if (SYS_RST_IN)
				begin
					cfg1_q[g] <= `GPE_RST_CFG1;
					cfg2_q[g] <= `GPE_RST_CFG2;
					route_q[g] <= `GPE_RST_ROUTE;
				end
				else if (cfg_wr && sel == g)
				begin
					if (CFG_IDX_IN == `GPE_IDX_CFG1)
					begin
						if (lock_v[g])
							cfg1_q[g][7:4] <= CFG_WDATA_IN[7:4];
						else
							cfg1_q[g] <= CFG_WDATA_IN;
					end
					else if (CFG_IDX_IN == `GPE_IDX_CFG2)
					begin
						if (lock_v[g])
							cfg2_q[g] <= {CFG_WDATA_IN[7:5],
								cfg2_q[g][4], CFG_WDATA_IN[3:0]};
						else
							cfg2_q[g] <= CFG_WDATA_IN;
					end
					else if (CFG_IDX_IN == `GPE_IDX_ROUTE)
						route_q[g] <= CFG_WDATA_IN;
				end
			end
			// synchroniser, then debounce counter
			always @(posedge REF_CLK_IN)
			begin
				if (SYS_RST_IN)
				begin
					sync1_q[g] <= 1'b0;
					sync2_q[g] <= 1'b0;
					stab_q[g] <= 1'b0;
					dcnt_q[g] <= {CW{1'b0}};
				end
				else
				begin
					sync1_q[g] <= PIN_IN[g];
					sync2_q[g] <= sync1_q[g];
					if (!cfg1_q[g][`GPE_C1_DBNC])
					begin
						stab_q[g] <= in_live;
						dcnt_q[g] <= {CW{1'b0}};
					end
					else if (in_live == stab_q[g])
						dcnt_q[g] <= {CW{1'b0}};
					else if (dcnt_q[g] >= DBNC_CYC[CW-1:0] - 1'b1)
					begin
						stab_q[g] <= in_live;
						dcnt_q[g] <= {CW{1'b0}};
					end
					else
						dcnt_q[g] <= dcnt_q[g] + 1'b1;
				end
			end
		end
	endgenerate

	// pin select and port mode
	always @(posedge REF_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			sel_q <= 8'h00;
			mode_q <= `GPE_RST_MODE;
		end
		else
		begin
			if (cfg_wr && CFG_IDX_IN == `GPE_IDX_SEL)
				sel_q <= CFG_WDATA_IN;
			if (cfg_wr && CFG_IDX_IN == `GPE_IDX_MODE)
				mode_q <= CFG_WDATA_IN;
		end
	end

	// data-out latch and event enables
	always @(posedge REF_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			dout_q <= `GPE_RST_DOUT;
			even_q <= {PINS{1'b0}};
		end
		else
		begin
			if (wr_dout || wr_dio)
				dout_q <= (RT_WDATA_IN & ~lock_v) | (dout_q & lock_v);
			if (wr_even)
				even_q <= RT_WDATA_IN;
		end
	end

	// status clears, status next value and routing bits
	integer r;
	always @*
	begin
		vddl_v = {PINS{1'b0}};
		route_v = {PINS{1'b0}};
		for (r = 0; r < PINS; r = r + 1)
		begin
			vddl_v[r] = cfg2_q[r][`GPE_C2_VDDL];
			route_v[r] = route_q[r][`GPE_RT_IRQ];
		end
		evst_clr_v = {PINS{1'b0}};
		if (wr_evst)
			evst_clr_v = RT_WDATA_IN;
		evst_drop_v = {PINS{1'b0}};
		if (pwr_fall)
			evst_drop_v = vddl_v;
		// a hit wins over a clear in the same cycle, so levels re-set
		evst_d = (evst_q & ~evst_clr_v & ~evst_drop_v) | hit_v;
	end

	// detector history, sticky status and pending bits
	always @(posedge REF_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			evst_q <= {PINS{1'b0}};
			det_q <= {PINS{1'b0}};
			det_prev_q <= {PINS{1'b0}};
			pend_q <= {PINS{1'b0}};
			pwr_prev_q <= 1'b0;
		end
		else
		begin
			pwr_prev_q <= MAIN_PWR_OK_IN;
			det_q <= stab_q;
			det_prev_q <= det_q;
			evst_q <= evst_d;
			pend_q <= evst_q & even_q;
		end
	end

	// pin drivers
	integer p;
	always @(posedge REF_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			PIN_OUT <= {PINS{1'b0}};
			PIN_OE_OUT <= {PINS{1'b0}};
			PIN_PU_OUT <= {PINS{1'b0}};
		end
		else
		begin
			for (p = 0; p < PINS; p = p + 1)
			begin
				PIN_OUT[p] <= dout_q[p];
				PIN_OE_OUT[p] <= cfg1_q[p][`GPE_C1_OE] && !prot_v[p] &&
					(!cfg1_q[p][`GPE_C1_OD] || !dout_q[p]);
				PIN_PU_OUT[p] <= cfg1_q[p][`GPE_C1_PU] && !prot_v[p];
			end
		end
	end

	// interrupt request toward the serializer
	always @(posedge REF_CLK_IN)
	begin
		if (SYS_RST_IN)
			IRQ_OUT <= 1'b0;
		else
			IRQ_OUT <= ev_open && |(pend_q & route_v);
	end

	// configuration read data
	always @(posedge REF_CLK_IN)
	begin
		if (SYS_RST_IN)
			CFG_RDATA_OUT <= 8'h00;
		else
		begin
			if (CFG_RD_IN)
			begin
				if (CFG_IDX_IN == `GPE_IDX_SEL)
					CFG_RDATA_OUT <= sel_q;
				else if (CFG_IDX_IN == `GPE_IDX_CFG1)
					CFG_RDATA_OUT <= cfg1_q[sel];
				else if (CFG_IDX_IN == `GPE_IDX_ROUTE)
					CFG_RDATA_OUT <= route_q[sel];
				else if (CFG_IDX_IN == `GPE_IDX_CFG2)
					CFG_RDATA_OUT <= cfg2_q[sel];
				else if (CFG_IDX_IN == `GPE_IDX_MODE)
					CFG_RDATA_OUT <= mode_q;
				else
					CFG_RDATA_OUT <= 8'h00;
			end
		end
	end

	// runtime read data
	always @(posedge REF_CLK_IN)
	begin
		if (SYS_RST_IN)
			RT_RDATA_OUT <= 8'h00;
		else
		begin
			if (RT_RD_IN)
			begin
				// bit n is pin n throughout
				if (RT_OFS_IN == `GPE_OFS_DIO && rt_open)
					RT_RDATA_OUT <= sync2_q;
				else if (!sep_mode)
					RT_RDATA_OUT <= 8'h00;
				else if (RT_OFS_IN == `GPE_OFS_DOUT && rt_open)
					RT_RDATA_OUT <= dout_q;
				else if (RT_OFS_IN == `GPE_OFS_DIN && rt_open)
					RT_RDATA_OUT <= sync2_q;
				else if (RT_OFS_IN == `GPE_OFS_EVEN && ev_open)
					RT_RDATA_OUT <= even_q;
				else if (RT_OFS_IN == `GPE_OFS_EVST && ev_open)
					RT_RDATA_OUT <= evst_q;
				else
					RT_RDATA_OUT <= 8'h00;
			end
		end
	end

endmodule

// ### gpe_port_properties.sv
// gpe_port_properties.sv: port-level assertions for gpe_port.
// assumes binding into every gpe_port instance.
`timescale 1ns/1ps
module gpe_chk #(
	parameter PINS = 8
)(
	// clock and state
	input wire REF_CLK_IN,
	input wire SYS_RST_IN,
	input wire MAIN_PWR_OK_IN,
	input wire MOD_ACTIVE_IN,
	// runtime bus
	input wire RT_WR_IN,
	input wire RT_RD_IN,
	input wire [2:0] RT_OFS_IN,
	input wire [7:0] RT_RDATA_OUT,
	// outputs
	input wire [PINS-1:0] PIN_OUT,
	input wire IRQ_OUT
);
	default clocking @(posedge REF_CLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	sequence idle_wr;
		RT_WR_IN && !MOD_ACTIVE_IN;
	endsequence
	sequence din_wr;
		RT_WR_IN && RT_OFS_IN == 3'h1;
	endsequence
	chk_idle_write: assert property (idle_wr |-> ##2 $stable(PIN_OUT))
		else $error("blocked write moved pins");
	chk_din_write: assert property (din_wr |-> ##2 $stable(PIN_OUT))
		else $error("input write moved pins");
	chk_irq_act: assert property (!MOD_ACTIVE_IN |=> !IRQ_OUT)
		else $error("request while inactive");
	chk_irq_pwr: assert property (!MAIN_PWR_OK_IN |=> !IRQ_OUT)
		else $error("request without power");
	chk_irq_cause: assert property ($rose(IRQ_OUT) |->
		$past(MOD_ACTIVE_IN && MAIN_PWR_OK_IN)) else $error("bad request");
	chk_rd_idle: assert property (RT_RD_IN && !MOD_ACTIVE_IN |=>
		RT_RDATA_OUT == 8'h00) else $error("read while inactive");
	chk_rd_nopwr: assert property (RT_RD_IN && !MAIN_PWR_OK_IN &&
		RT_OFS_IN[2:1] == 2'h1 |=> RT_RDATA_OUT == 8'h00)
		else $error("event read without power");
	chk_rd_hold: assert property (!RT_RD_IN |=> $stable(RT_RDATA_OUT))
		else $error("read data moved");
endmodule
bind gpe_port gpe_chk #(.PINS(PINS)) chk_u (.REF_CLK_IN(REF_CLK_IN),
	.SYS_RST_IN(SYS_RST_IN), .MAIN_PWR_OK_IN(MAIN_PWR_OK_IN),
	.MOD_ACTIVE_IN(MOD_ACTIVE_IN), .RT_WR_IN(RT_WR_IN), .RT_RD_IN(RT_RD_IN),
	.RT_OFS_IN(RT_OFS_IN), .RT_RDATA_OUT(RT_RDATA_OUT), .PIN_OUT(PIN_OUT),
	.IRQ_OUT(IRQ_OUT));

// ### gpe_port_test.sv
// gpe_port_test.sv: self-checking bench for gpe_port.
// assumes an 8-cycle debounce and pins resolved by gpe_pins_model.
`timescale 1ns/1ps
module gpe_port_test;
	reg clk = 0, rst = 1, pwr = 1, act = 1, cw = 0, cr = 0, rw = 0, rr = 0;
	reg [7:0] ci = 0, cd = 0, ext = 0, r = 8'h51;
	reg [2:0] ro = 0;
	wire [7:0] crd, rrd, po, poe, ppu, pin;
	wire irq;
	integer error_cnt = 0, num_checks = 0;
	always #10 clk = ~clk;
	gpe_port #(.DBNC_CYC(8)) dut_u (.REF_CLK_IN(clk), .SYS_RST_IN(rst),
		.MAIN_PWR_OK_IN(pwr), .MOD_ACTIVE_IN(act), .CFG_WR_IN(cw),
		.CFG_RD_IN(cr), .CFG_IDX_IN(ci), .CFG_WDATA_IN(cd),
		.CFG_RDATA_OUT(crd), .RT_WR_IN(rw), .RT_RD_IN(rr), .RT_OFS_IN(ro),
		.RT_WDATA_IN(cd), .RT_RDATA_OUT(rrd), .PIN_IN(pin), .PIN_OUT(po),
		.PIN_OE_OUT(poe), .PIN_PU_OUT(ppu), .IRQ_OUT(irq));
	gpe_pins_model pins_u (.drv_in(po), .oe_in(poe), .ext_in(ext),
		.level_out(pin));
	function [7:0] nx(input [7:0] s);
		nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task wrap_up;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input [7:0] s, e);
		num_checks = num_checks + 1;
		if (s !== e)
		begin
			error_cnt = error_cnt + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one bus access; c picks config or runtime, w picks write
	task acc(input c, w, input [7:0] a, d, e);
		@(negedge clk);
		{cw, cr, rw, rr} = {c & w, c & !w, !c & w, !c & !w};
		ci = a;
		ro = a[2:0];
		cd = d;
		@(negedge clk);
		{cw, cr, rw, rr} = 4'h0;
		if (!w)
			chk(c ? crd : rrd, e);
	endtask
	task pc(input [7:0] p, v);
		acc(1, 1, 8'hF0, p, 0);
		acc(1, 1, 8'hF1, v, 0);
	endtask
	task wt(input e);
		integer i;
		for (i = 0; i < 40 && irq !== e; i = i + 1)
			@(negedge clk);
		chk(irq, e);
		if (irq !== e)
			wrap_up;
	endtask
	initial
	begin
		repeat (8) @(negedge clk);
		rst = 0;
		acc(1, 0, 8'hF1, 0, 8'h40);
		acc(1, 0, 8'hF2, 0, 8'h01);
		acc(0, 0, 0, 0, 8'hFF);
		repeat (4)
		begin
			r = nx(r);
			ext = r;
			acc(0, 1, 0, r, 0);
			acc(0, 1, 1, ~r, 0);
			acc(0, 0, 0, 0, r);
			chk(po, r);
			acc(0, 0, 4, 0, r);
		end
		acc(0, 1, 4, 8'h5A, 0);
		acc(0, 0, 0, 0, 8'h5A);
		ext = 8'hFF;
		pc(0, 8'h05);
		repeat (4) @(negedge clk);
		acc(0, 0, 1, 0, 8'hFE);
		chk(poe & ppu, 8'h01);
		pc(0, 8'h07);
		acc(0, 1, 0, 8'h01, 0);
		@(negedge clk);
		chk(poe, 8'h00);
		pc(0, 8'h0F);
		acc(0, 1, 4, 8'h00, 0);
		acc(0, 0, 0, 0, 8'h01);
		acc(1, 1, 8'hF1, 8'h00, 0);
		acc(1, 0, 8'hF1, 0, 8'h0F);
		ext = 0;
		repeat (20) @(negedge clk);
		pc(3, 8'h20);
		pc(2, 8'h10);
		pc(1, 8'h20);
		acc(1, 1, 8'hF3, 8'h10, 0);
		acc(0, 1, 3, 8'hFF, 0);
		acc(0, 1, 2, 8'h02, 0);
		wt(0);
		acc(0, 0, 3, 0, 8'h04);
		ext = 8'h0A;
		wt(1);
		acc(0, 0, 3, 0, 8'h0E);
		acc(1, 1, 8'hF2, 0, 0);
		wt(0);
		acc(1, 1, 8'hF2, 8'h01, 0);
		wt(1);
		act = 0;
		wt(0);
		acc(0, 1, 0, 8'hFF, 0);
		acc(0, 0, 0, 0, 0);
		act = 1;
		acc(0, 0, 0, 0, 8'h01);
		ext = 8'h08;
		repeat (10) @(negedge clk);
		pwr = 0;
		wt(0);
		acc(0, 0, 3, 0, 0);
		pwr = 1;
		wt(0);
		acc(0, 0, 3, 0, 8'h0C);
		acc(0, 1, 3, 8'h0C, 0);
		acc(0, 0, 3, 0, 8'h04);
		acc(1, 1, 8'hF8, 0, 0);
		acc(1, 0, 8'hF8, 0, 8'h00);
		acc(0, 0, 3, 0, 0);
		acc(1, 1, 8'hF8, 8'h01, 0);
		pc(5, 8'h60);
		ext = 8'h28;
		repeat (3) @(negedge clk);
		ext = 8'h08;
		repeat (20) @(negedge clk);
		acc(0, 0, 3, 0, 8'h04);
		ext = 8'h28;
		repeat (30) @(negedge clk);
		acc(0, 0, 3, 0, 8'h24);
		wrap_up;
	end
endmodule
